//--- hw/teib_pkg.sv
// Package of constants for the threshold edge interrupt enable bank.
package teib_pkg;
    localparam int REG_WIDTH = 24;
    localparam logic [7:0] EDGE_ENABLE_ADDR = 8'h27;
    localparam logic [23:0] EDGE_ENABLE_RESET = 24'h000000;
    localparam int NUM_INPUTS = 4;
    localparam int NUM_THRESH = 3;
    localparam int FIELD_WIDTH = 6;
    localparam int FIRST_INPUT = 18;
    localparam int SW18_LSB = 0;
    localparam int SW19_LSB = 6;
    localparam int SW20_LSB = 12;
    localparam int SW21_LSB = 18;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_RISE = 2'h1;
    localparam logic [1:0] SEL_FALL = 2'h2;
    localparam logic [1:0] SEL_BOTH = 2'h3;
    localparam int SYNC_STAGES = 3;
endpackage

//--- hw/teib_sel_if.sv
// Interface carrying the edge selectors and comparator levels of one input.
`timescale 1ns/1ps
interface teib_sel_if;
    logic [5:0] edge_select;
    logic [2:0] level;
    logic [2:0] level_prev;
    logic hit;
    modport bank (output edge_select, output level, output level_prev,
                  input hit);
    modport eval (input edge_select, input level, input level_prev,
                  output hit);
endinterface

//--- hw/teib_edge_eval.sv
// Edge evaluator of one switch input against its three thresholds.
`timescale 1ns/1ps
module teib_edge_eval
    import teib_pkg::*;
(
    teib_sel_if.eval sel
);
    // Decoding of one two-bit selector against one level transition.
    function automatic logic edge_hit(input logic [1:0] code,
                                      input logic now_lvl,
                                      input logic old_lvl);
        logic rise;
        logic fall;
        rise = now_lvl & ~old_lvl;
        fall = ~now_lvl & old_lvl;
        unique case (code)
            SEL_NONE: edge_hit = 1'b0;
            SEL_RISE: edge_hit = rise;
            SEL_FALL: edge_hit = fall;
            SEL_BOTH: edge_hit = rise | fall;
        endcase
    endfunction

    logic [NUM_THRESH-1:0] per_thresh;

    genvar t;
    generate
        for (t = 0; t < NUM_THRESH; t++) begin : g_thresh
            assign per_thresh[t] = edge_hit(sel.edge_select[2*t+1 -: 2],
                                            sel.level[t],
                                            sel.level_prev[t]);
        end
    endgenerate

    assign sel.hit = |per_thresh;
endmodule // teib_edge_eval

//--- hw/teib_bank.sv
// Interrupt edge enable register for switch inputs 18 to 21 with evaluation.
//
// Summary of operation
// - A 24-bit read/write register at address 0x27 clears to zero on reset.
// - Bits 23 to 18 select the interrupt edges of switch input 21.
// - Bits 17 to 12 select the interrupt edges of switch input 20.
// - Bits 11 to 6 select the interrupt edges of switch input 19.
// - Bits 5 to 0 select the interrupt edges of switch input 18.
// - The low bit pair codes none, rising, falling or both for threshold one.
// - The middle bit pair uses the same code for threshold two.
// - The upper bit pair uses the same code for threshold three.
`timescale 1ns/1ps
module teib_bank
    import teib_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_reg_write,
    input wire logic [ADDR_WIDTH-1:0] i_reg_addr,
    input wire logic [REG_WIDTH-1:0] i_reg_wdata,
    input wire logic [NUM_INPUTS*NUM_THRESH-1:0] i_level,
    output logic [REG_WIDTH-1:0] o_reg_rdata,
    output logic o_addr_hit,
    output logic [NUM_INPUTS-1:0] o_switch_request
);
    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [REG_WIDTH-1:0] edge_enable;
    logic [REG_WIDTH-1:0] next_edge_enable;
    logic [REG_WIDTH-1:0] next_rdata;
    logic next_addr_hit;
    logic addr_match;

    assign addr_match = (i_reg_addr == ADDR_WIDTH'(EDGE_ENABLE_ADDR));

    always_comb begin
        next_edge_enable = edge_enable;
        if (i_reg_write && addr_match) begin
            next_edge_enable = i_reg_wdata;
        end
        // Unmapped addresses read as zero.
        next_rdata = addr_match ? next_edge_enable : '0;
        next_addr_hit = addr_match;
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            edge_enable <= EDGE_ENABLE_RESET;
            o_reg_rdata <= '0;
            o_addr_hit <= 1'b0;
        end else begin
            edge_enable <= next_edge_enable;
            o_reg_rdata <= next_rdata;
            o_addr_hit <= next_addr_hit;
        end
    end

    // ------------------------------------------------------------------
    // Comparator level synchronisers
    // ------------------------------------------------------------------
    // Comparator results come from the analog front end, so each passes
    // three flops and only counts once the last two agree.
    localparam int NL = NUM_INPUTS*NUM_THRESH;
    logic [NL-1:0] sync1, sync2, sync3, stable, stable_prev;
    logic [NL-1:0] next_stable;

    always_comb begin
        next_stable = stable;
        for (int b = 0; b < NL; b++) begin
            if (sync2[b] == sync3[b]) begin
                next_stable[b] = sync3[b];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            stable <= '0;
            stable_prev <= '0;
        end else begin
            sync1 <= i_level;
            sync2 <= sync1;
            sync3 <= sync2;
            stable <= next_stable;
            stable_prev <= stable;
        end
    end

    // ------------------------------------------------------------------
    // Per-input evaluation
    // ------------------------------------------------------------------
    localparam int FIELD_LSB [NUM_INPUTS] = '{SW18_LSB, SW19_LSB,
                                              SW20_LSB, SW21_LSB};
    logic [NUM_INPUTS-1:0] hit;
    logic [NUM_INPUTS-1:0] next_request;

    genvar n;
    generate
        for (n = 0; n < NUM_INPUTS; n++) begin : g_input
            teib_sel_if sel ();
            assign sel.edge_select =
                edge_enable[FIELD_LSB[n] +: FIELD_WIDTH];
            assign sel.level = stable[n*NUM_THRESH +: NUM_THRESH];
            assign sel.level_prev =
                stable_prev[n*NUM_THRESH +: NUM_THRESH];
            assign hit[n] = sel.hit;
            teib_edge_eval u_eval (
                .sel(sel)
            );
        end
    endgenerate

    always_comb begin
        next_request = hit;
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_switch_request <= '0;
        end else begin
            o_switch_request <= next_request;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_reset_clears: assert property (@(posedge i_clk)
        !i_resetn |=> edge_enable == '0)
        else $error("edge enable not cleared by reset");

    a_write_stores: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        i_reg_write && addr_match |=> edge_enable == $past(i_reg_wdata))
        else $error("write to edge enable not stored");

    a_other_addr_keep: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        !(i_reg_write && addr_match) |=> $stable(edge_enable))
        else $error("edge enable changed without write");

    a_readback_match: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        addr_match && !i_reg_write |=> o_reg_rdata == edge_enable)
        else $error("readback differs from register");

    a_sw21_disabled: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        edge_enable[23:18] == '0 |=> !o_switch_request[3])
        else $error("input 21 request while disabled");

    a_sw20_disabled: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        edge_enable[17:12] == '0 |=> !o_switch_request[2])
        else $error("input 20 request while disabled");

    a_sw19_disabled: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        edge_enable[11:6] == '0 |=> !o_switch_request[1])
        else $error("input 19 request while disabled");

    a_sw18_rise_first: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        edge_enable[1:0] == SEL_RISE && stable[0] && !stable_prev[0]
        |=> o_switch_request[0])
        else $error("input 18 rising edge missed");

    a_sw18_fall_only: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        edge_enable[5:0] == 6'h02 && stable[0] && !stable_prev[0]
        |=> !o_switch_request[0])
        else $error("falling selector fired on rise");

    a_sw18_both_second: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        edge_enable[3:2] == SEL_BOTH && stable[1] != stable_prev[1]
        |=> o_switch_request[0])
        else $error("second threshold both edges missed");

    a_sw18_fall_third: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        edge_enable[5:4] == SEL_FALL && !stable[2] && stable_prev[2]
        |=> o_switch_request[0])
        else $error("third threshold falling edge missed");

    a_no_change_quiet: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        stable == stable_prev |=> o_switch_request == '0)
        else $error("request without a level change");

    a_unmapped_quiet: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        !addr_match |=> o_reg_rdata == '0 && !o_addr_hit)
        else $error("unmapped address returned data");

    a_mapped_hit: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        addr_match |=> o_addr_hit)
        else $error("mapped address not flagged");

    a_sw21_rise_third: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        edge_enable[SW21_LSB+4 +: 2] == SEL_RISE &&
        stable[11] && !stable_prev[11] |=> o_switch_request[3])
        else $error("input 21 third threshold rise missed");

    a_sw20_fall_first: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        edge_enable[SW20_LSB +: 2] == SEL_FALL &&
        !stable[6] && stable_prev[6] |=> o_switch_request[2])
        else $error("input 20 first threshold fall missed");

    a_sw19_both_second: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        edge_enable[SW19_LSB+2 +: 2] == SEL_BOTH &&
        stable[4] != stable_prev[4] |=> o_switch_request[1])
        else $error("input 19 second threshold edge missed");

    a_sw18_disabled: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        edge_enable[SW18_LSB +: FIELD_WIDTH] == '0
        |=> !o_switch_request[0])
        else $error("input 18 request while disabled");
endmodule // teib_bank

//--- verif/tb_top.sv
// Self-checking testbench of the threshold edge interrupt enable bank.
`timescale 1ns/1ps
module tb_top
    import teib_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_reg_write = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [23:0] i_reg_wdata = 24'h000000;
    logic [11:0] i_level = 12'h000;
    logic [23:0] o_reg_rdata;
    logic o_addr_hit;
    logic [3:0] o_switch_request;
    int n_errors = 0;
    int n_compared = 0;

    teib_bank teib_bank_i (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_reg_write(i_reg_write),
        .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .i_level(i_level),
        .o_reg_rdata(o_reg_rdata),
        .o_addr_hit(o_addr_hit),
        .o_switch_request(o_switch_request)
    );

    always #5 i_clk = ~i_clk;

    // ----------------------------------------------------------------
    // Access and checking tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Called at a falling edge; the strobe lasts exactly one cycle.
    // An idle cycle follows, so a second call never raises the strobe in
    // the same time step that lowered it.
    task automatic write_reg(input logic [7:0] a, input logic [23:0] d);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_write = 1'b1;
        @(negedge i_clk);
        i_reg_write = 1'b0;
        @(negedge i_clk);
    endtask

    task automatic read_reg(input logic [7:0] a, input logic [23:0] exp,
                            input logic hit);
        i_reg_addr = a;
        @(negedge i_clk);
        check(o_reg_rdata, exp);
        check({23'h0, o_addr_hit}, {23'h0, hit});
    endtask

    // Levels pass a three-stage synchroniser, so the request pulse lands
    // about five cycles later; ten cycles leave margin without overlap.
    task automatic level_step(input logic [11:0] lv, input logic [3:0] exp);
        logic [3:0] seen;
        logic [23:0] pulses;
        seen = 4'h0;
        pulses = 24'h0;
        i_level = lv;
        repeat (10) begin
            @(negedge i_clk);
            seen = seen | o_switch_request;
            if (o_switch_request !== 4'h0) begin
                pulses = pulses + 24'h1;
            end
        end
        check({20'h0, seen}, {20'h0, exp});
        check(pulses, {23'h0, exp != 4'h0});
    endtask

    task automatic wrap_up;
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(negedge i_clk);
        i_resetn = 1'b1;
        check({20'h0, o_switch_request}, 24'h0);
        read_reg(EDGE_ENABLE_ADDR, EDGE_ENABLE_RESET, 1'b1);
        read_reg(8'h26, 24'h0, 1'b0);
        write_reg(EDGE_ENABLE_ADDR, 24'h5a3c96);
        check(o_reg_rdata, 24'h5a3c96);
        write_reg(8'h28, 24'hffffff);
        read_reg(EDGE_ENABLE_ADDR, 24'h5a3c96, 1'b1);
        read_reg(8'h28, 24'h0, 1'b0);
        // One selector at a time, so a misplaced field fires the wrong bit.
        for (int n = 0; n < 4; n++) begin
            for (int t = 0; t < 3; t++) begin
                for (int c = 0; c < 4; c++) begin
                    write_reg(EDGE_ENABLE_ADDR, 24'(c) << (n * 6 + t * 2));
                    level_step(12'h1 << (n * 3 + t),
                               c[0] ? 4'h1 << n : 4'h0);
                    level_step(12'h000,
                               c[1] ? 4'h1 << n : 4'h0);
                end
            end
        end
        write_reg(EDGE_ENABLE_ADDR, 24'h041041);
        level_step(12'hfff, 4'hf);
        level_step(12'h000, 4'h0);
        write_reg(EDGE_ENABLE_ADDR, 24'hffffff);
        level_step(12'h492, 4'hf);
        level_step(12'h000, 4'hf);
        i_resetn = 1'b0;
        repeat (2) @(negedge i_clk);
        i_resetn = 1'b1;
        read_reg(EDGE_ENABLE_ADDR, EDGE_ENABLE_RESET, 1'b1);
        level_step(12'hfff, 4'h0);
        wrap_up();
    end
endmodule // tb_top
